/* File: logic/autoneg_local_advert_ahb_slave.v */
/*
 AHB-Lite slave front end: latches address phase, gives write strobe.
 Assumes single word transfers; always zero wait states, OKAY.
*/
`timescale 1ns/1ps
`default_nettype none
`include "autoneg_local_advert_consts.vh"
module aar_ahb_slave (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [7:0]  addr_q,
   output reg         wr_q,
   output reg         rd_q
);
   wire valid;   // Accepted transfer this cycle

   assign valid = hsel & hready & htrans[1] & (hsize == `AAR_HSIZE_WORD);
   assign hreadyout = 1'b1;
   assign hresp     = `AAR_HRESP_OKAY;

   // Capture address phase for the following data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= 8'h00;
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
      end else begin
         if (hready) begin
            addr_q <= haddr[7:0];
            wr_q   <= valid & hwrite;
            rd_q   <= valid & ~hwrite;
         end
      end
   end
endmodule
`default_nettype wire

/* File: logic/autoneg_local_advert_consts.vh */
/*
 Constants for the auto-negotiation ability register bank.
 Assumes inclusion by bare name from the logic/ folder.
*/
// Overview of operation
// - Advertisement register, read/write, resets to 05E1h.
// - Bit 15 requests next-page exchange, reset zero.
// - Advertisement bit 14 ignores writes, reads zero.
// - Bit 13 advertises detected remote fault.
// - Bits 12:11 read zero; software writes zero.
// - Bit 10 pause advert, reset from configuration.
// - Bit 9 four-pair ability fixed at zero.
// - Bits 8:5 speeds, reset from select configuration.
// - Bits 4:0 selector, default 00001.
// - Partner register read-only, resets 0000h, captures word.
// - Partner word may change after completion.
// - Partner bit 14 acknowledge from state machine.
// - Partner bits 15 and 13 next-page, fault.
// - Partner bits 9:5 abilities, 4:0 selector.
`ifndef AAR_CONSTS_VH
`define AAR_CONSTS_VH

`define AAR_OFF_ADVERT      8'h90
`define AAR_OFF_PARTNER     8'h94
`define AAR_OFF_EXPANSION   8'h98
`define AAR_ADDR_LSB        2
`define AAR_ADDR_MSB        7

`define AAR_RST_ADVERT      16'h05E1
`define AAR_RST_PARTNER     16'h0000
`define AAR_RST_EXPANSION   16'h0004
`define AAR_SELECTOR_RST    5'h01

// Advertisement bit positions
`define AAR_BIT_NEXT_PAGE   15
// Bit 14: reserved in advertisement, acknowledge in partner word
`define AAR_BIT_ACK         14
`define AAR_BIT_FAULT       13
`define AAR_BIT_PAUSE       10
`define AAR_BIT_FOURPAIR    9
`define AAR_SPD_MSB         8
`define AAR_SPD_LSB         5
`define AAR_SEL_MSB         4
`define AAR_SEL_LSB         0

// Strap vector: pause on top, speed select below
`define AAR_STRAP_PAUSE     4
`define AAR_STRAP_SPD_MSB   3
`define AAR_STRAP_SPD_LSB   0

// Writable bits of the advertisement register
`define AAR_ADV_WMASK       16'hA5FF
// Defined bits of the partner register
`define AAR_PARTNER_MASK    16'hE3FF

// Bus encodings
`define AAR_HTRANS_NONSEQ   2'h2
`define AAR_HTRANS_SEQ      2'h3
`define AAR_HSIZE_WORD      3'h2
`define AAR_HRESP_OKAY      1'h0

`endif

/* File: logic/autoneg_local_advert_regs.v */
/*
 Auto-negotiation ability registers: local advertisement, partner
 ability capture and expansion status, reached over AHB-Lite.
 Assumes the negotiation state machine drives the partner capture
 and status inputs synchronously on hclk; straps are raw pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "autoneg_local_advert_consts.vh"
module aar_regs (
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   // Configuration pins
   input  wire        flow_control_advertise_cfg,
   input  wire [3:0]  negotiation_select_cfg,
   // Negotiation engine side
   input  wire        partner_word_valid,
   input  wire [15:0] partner_word,
   input  wire        partner_ack_set,
   input  wire        partner_ack_clr,
   input  wire        autoneg_complete,
   input  wire        next_page_able,
   input  wire [15:0] expansion_status_in,
   output wire [15:0] local_ability_word,
   output wire        next_page_request,
   output wire        remote_fault_flag
);
   wire [7:0]  addr_q;      // Data-phase address
   wire        wr_q;        // Data-phase write
   wire        rd_q;        // Data-phase read
   wire [4:0]  strap_q;     // Captured straps
   wire        strap_valid; // Straps captured

   reg  [15:0] advert_q;    // Local advertisement storage
   reg         strap_done_q;// Strap defaults applied
   reg  [15:0] partner_q;   // Partner ability word
   reg  [15:0] expansion_q; // Expansion status

   aar_ahb_slave u_bus (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .addr_q    (addr_q),
      .wr_q      (wr_q),
      .rd_q      (rd_q)
   );

   aar_strap_capture #(.W(5)) u_strap (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .strap_in ({flow_control_advertise_cfg, negotiation_select_cfg}),
      .strap_q  (strap_q),
      .valid_q  (strap_valid)
   );

   // Match an address-phase or data-phase address against a register offset
   function hit;
      input [7:0] a;
      input [7:0] off;
      begin
         hit = (a[`AAR_ADDR_MSB:`AAR_ADDR_LSB] == off[`AAR_ADDR_MSB:`AAR_ADDR_LSB]);
      end
   endfunction

   // Advertisement register: reset, strap defaults, software writes
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         advert_q     <= `AAR_RST_ADVERT;
         strap_done_q <= 1'b0;
      end else begin
         if (strap_valid && !strap_done_q) begin
            strap_done_q <= 1'b1;
            advert_q[`AAR_BIT_PAUSE] <= strap_q[`AAR_STRAP_PAUSE];
            advert_q[`AAR_SPD_MSB:`AAR_SPD_LSB] <=
               strap_q[`AAR_STRAP_SPD_MSB:`AAR_STRAP_SPD_LSB];
         end else if (wr_q && hit(addr_q, `AAR_OFF_ADVERT)) begin
            // Only writable bits land; fixed bits stay zero
            advert_q <= hwdata[15:0] & `AAR_ADV_WMASK;
         end
      end
   end

   // Partner ability capture; bus writes never touch it
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         partner_q <= `AAR_RST_PARTNER;
      end else begin
         if (partner_word_valid && (!autoneg_complete || next_page_able)) begin
            // After completion only next-page exchange or the ack set/clear inputs may update it
            partner_q <= partner_word & `AAR_PARTNER_MASK;
         end else if (partner_ack_set) begin
            partner_q[`AAR_BIT_ACK] <= 1'b1;
         end else if (partner_ack_clr) begin
            partner_q[`AAR_BIT_ACK] <= 1'b0;
         end
      end
   end

   // Expansion status mirror of engine state
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         expansion_q <= `AAR_RST_EXPANSION;
      end else begin
         expansion_q <= expansion_status_in;
      end
   end

   // Read data for the data phase; unmapped reads give zero
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else begin
         if (hsel && hready && htrans[1] && !hwrite) begin
            if (hit(haddr[7:0], `AAR_OFF_ADVERT)) begin
               hrdata <= {16'h0000, advert_q};
            end else if (hit(haddr[7:0], `AAR_OFF_PARTNER)) begin
               hrdata <= {16'h0000, partner_q};
            end else if (hit(haddr[7:0], `AAR_OFF_EXPANSION)) begin
               hrdata <= {16'h0000, expansion_q};
            end else begin
               hrdata <= 32'h00000000;
            end
         end
      end
   end

   assign local_ability_word = advert_q;
   assign next_page_request  = advert_q[`AAR_BIT_NEXT_PAGE];
   assign remote_fault_flag  = advert_q[`AAR_BIT_FAULT];

endmodule
`default_nettype wire

/* File: logic/autoneg_local_advert_strap_capture.v */
/*
 Captures configuration straps once after reset release.
 Assumes straps are static pins from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module aar_strap_capture #(
   parameter W = 5
) (
   input  wire         hclk,
   input  wire         hresetn,
   input  wire [W-1:0] strap_in,
   output reg  [W-1:0] strap_q,
   output reg          valid_q
);
   reg [W-1:0] sync1_q;   // First stage, read only by second
   reg [W-1:0] sync2_q;   // Second stage
   reg [1:0]   cnt_q;     // Settle counter

   // Two-stage synchroniser then one-time capture
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= {W{1'b0}};
         sync2_q <= {W{1'b0}};
         strap_q <= {W{1'b0}};
         cnt_q   <= 2'h0;
         valid_q <= 1'b0;
      end else begin
         sync1_q <= strap_in;
         sync2_q <= sync1_q;
         if (!valid_q) begin
            // Wait until sync chain holds real pin data
            if (cnt_q == 2'h2) begin
               strap_q <= sync2_q;
               valid_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 2'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: verification/aar_partner.sv */
/* Model of the negotiation engine relaying the remote partner's pages.
   Assumes its tasks are entered just after a rising hclk edge. */
`timescale 1ns/1ps
`default_nettype none
module aar_partner (
   input  wire logic        hclk,
   output var  logic        partner_word_valid,
   output var  logic [15:0] partner_word,
   output var  logic        partner_ack_set,
   output var  logic        partner_ack_clr,
   output var  logic        autoneg_complete,
   output var  logic        next_page_able,
   output var  logic [15:0] expansion_status_in
);
   // Idle, not complete, expansion at its reset pattern
   initial begin
      {partner_word_valid, partner_ack_set, partner_ack_clr} = 3'h0;
      {autoneg_complete, next_page_able} = 2'h0;
      partner_word = 16'h0000;
      expansion_status_in = 16'h0004;
   end
   // One received page, word scrambled once released
   task automatic page(input logic [15:0] w);
      partner_word_valid <= 1'b1;
      partner_word <= w;
      @(posedge hclk);
      partner_word_valid <= 1'b0;
      partner_word <= ~w;
   endtask
   // Acknowledge seen or lost in the bursts
   task automatic ack(input logic s);
      partner_ack_set <= s;
      partner_ack_clr <= !s;
      @(posedge hclk);
      {partner_ack_set, partner_ack_clr} <= 2'h0;
   endtask
   // New expansion status level, mirrored one edge later
   task automatic status(input logic [15:0] v);
      expansion_status_in <= v;
      @(posedge hclk);
   endtask
   // Negotiation outcome levels
   task automatic state(input logic c, input logic n);
      autoneg_complete <= c;
      next_page_able <= n;
      @(posedge hclk);
   endtask
endmodule
`default_nettype wire

/* File: verification/aar_regs_asserts.sv */
/* Checker for the ability register bank, watching its ports only.
   Assumes one hclk domain and hready fed back from hreadyout. */
`timescale 1ns/1ps
`default_nettype none
module aar_asserts (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic [15:0] expansion_status_in,
   input wire logic [15:0] local_ability_word,
   input wire logic        next_page_request,
   input wire logic        remote_fault_flag
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Address phase taken at this edge
   wire logic ap = hsel && hreadyout && htrans[1];
   property p_b14; local_ability_word[14] == 1'b0; endproperty
   a_b14: assert property (p_b14) else $error("adv bit 14 set");
   property p_b1211; local_ability_word[12:11] == 2'h0; endproperty
   a_b1211: assert property (p_b1211) else $error("adv bits 12:11 set");
   property p_b9; !local_ability_word[9]; endproperty
   a_b9: assert property (p_b9) else $error("adv bit 9 set");
   property p_np; next_page_request == local_ability_word[15]; endproperty
   a_np: assert property (p_np) else $error("next page flag wrong");
   property p_rf; remote_fault_flag == local_ability_word[13]; endproperty
   a_rf: assert property (p_rf) else $error("fault flag wrong");
   property p_wr;
      ap && hwrite && haddr[7:0] == 8'h90 ##1 1'b1
         |=> local_ability_word == ($past(hwdata[15:0]) & 16'hA5FF);
   endproperty
   a_wr: assert property (p_wr) else $error("adv write lost");
   property p_exp;
      ap && !hwrite && haddr[7:0] == 8'h98 |=> hrdata[15:0] == $past(expansion_status_in, 2);
   endproperty
   a_exp: assert property (p_exp) else $error("expansion read wrong");
   property p_lp; ap && !hwrite && haddr[7:0] == 8'h94 |=> hrdata[12:10] == 3'h0; endproperty
   a_lp: assert property (p_lp) else $error("partner bits 12:10 set");
   property p_hi; ap && !hwrite |=> hrdata[31:16] == 16'h0000; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   // Main traffic kinds
   c_wr: cover property (ap && hwrite);
   c_lp: cover property (ap && !hwrite && haddr[7:0] == 8'h94);
   c_np: cover property (next_page_request);
endmodule
bind aar_regs aar_asserts chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hreadyout(hreadyout), .hrdata(hrdata), .expansion_status_in(expansion_status_in),
   .local_ability_word(local_ability_word), .next_page_request(next_page_request),
   .remote_fault_flag(remote_fault_flag));
`default_nettype wire

/* File: verification/autoneg_ability_registers_tb_top.sv */
/* Bench for the ability register bank over AHB-Lite.
   Assumes zero wait states and straps held static from time zero until changed before the second reset. */
`timescale 1ns/1ps
`default_nettype none
module autoneg_ability_registers_tb_top;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pause = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [3:0] sel = 4'hA;
   wire logic hreadyout, hresp, pv, pas, pac, ac, npa, np, rf;
   wire logic [31:0] hrdata;
   wire logic [15:0] pw, es, law;
   integer n_errors = 0, n_checks = 0;
   always #10 hclk = ~hclk;
   aar_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .flow_control_advertise_cfg(pause), .negotiation_select_cfg(sel),
      .partner_word_valid(pv), .partner_word(pw), .partner_ack_set(pas),
      .partner_ack_clr(pac), .autoneg_complete(ac), .next_page_able(npa),
      .expansion_status_in(es), .local_ability_word(law),
      .next_page_request(np), .remote_fault_flag(rf));
   aar_partner pm_u (.hclk(hclk), .partner_word_valid(pv), .partner_word(pw),
      .partner_ack_set(pas), .partner_ack_clr(pac), .autoneg_complete(ac),
      .next_page_able(npa), .expansion_status_in(es));
   task automatic complete_run;
      if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      n_checks++;
      if (got !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, e);
      end
   endtask
   // Next edge with hready high, bounded
   task automatic wait_rdy;
      integer i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 50);
      if (hreadyout !== 1'b1) begin
         n_errors++;
         complete_run;
      end
   endtask
   // One single word transfer, read data compared
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      chk({31'h0, hresp}, 32'h0);
      if (!w) chk(hrdata, e);
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      chk({16'h0, law}, 32'h05E1);
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
      xfer(1'b0, 8'h90, 0, {21'h0, pause, 1'b0, sel, 5'h01});
      xfer(1'b0, 8'h94, 0, 32'h0000);
      xfer(1'b0, 8'h98, 0, 32'h0004);
      xfer(1'b1, 8'h90, 32'hE7FF, 0);
      xfer(1'b0, 8'h90, 0, 32'hA5FF);
      chk({30'h0, np, rf}, 32'h3);
      xfer(1'b1, 8'h90, 32'h0, 0);
      xfer(1'b0, 8'h90, 0, 32'h0000);
      xfer(1'b1, 8'h94, 32'hFFFF, 0);
      xfer(1'b1, 8'h98, 32'hFFFF, 0);
      xfer(1'b0, 8'h94, 0, 32'h0000);
      xfer(1'b0, 8'h98, 0, 32'h0004);
      xfer(1'b0, 8'h9C, 0, 32'h0000);
      pm_u.page(16'hFFFF);
      xfer(1'b0, 8'h94, 0, 32'hE3FF);
      pm_u.ack(1'b0);
      xfer(1'b0, 8'h94, 0, 32'hA3FF);
      pm_u.ack(1'b1);
      xfer(1'b0, 8'h94, 0, 32'hE3FF);
      pm_u.state(1'b1, 1'b0);
      pm_u.page(16'h0021);
      xfer(1'b0, 8'h94, 0, 32'hE3FF);
      pm_u.state(1'b1, 1'b1);
      pm_u.page(16'h0021);
      xfer(1'b0, 8'h94, 0, 32'h0021);
      pm_u.status(16'h000B);
      xfer(1'b0, 8'h98, 0, 32'h000B);
      // Second reset with other straps; defaults must follow them
      pause <= 1'b1;
      sel <= 4'h5;
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk({16'h0, law}, 32'h05E1);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
      xfer(1'b0, 8'h90, 0, {21'h0, pause, 1'b0, sel, 5'h01});
      xfer(1'b0, 8'h94, 0, 32'h0000);
      complete_run;
   end
endmodule
`default_nettype wire
